// [dv/cps_pneu_model.sv]
// model: pump, valves and cuff; cuff vents when the common supply drops
`timescale 1ns/1ns
module cps_pneu_model
	import cps_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [CPS_PW-1:0] level,
	input wire logic pump_on,
	input wire logic pneu_power_on,
	output logic [CPS_PW-1:0] cuff_pressure
);
	logic vent_reg;
	logic pwr_reg;
	logic vent_next;
	// valves fall open on supply loss and stay open until the cuff is emptied
	assign vent_next = (vent_reg || (pwr_reg && !pneu_power_on)) && (level != '0);
	assign cuff_pressure = vent_reg ? '0 : level + {9'h000, pump_on & pneu_power_on};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vent_reg <= 1'b0;
			pwr_reg <= 1'b0;
		end else begin
			vent_reg <= vent_next;
			pwr_reg <= pneu_power_on;
		end
	end
endmodule

// [dv/cps_supervisor_checker.sv]
// checker: port-level assertions for the cuff pressure supervisor
`timescale 1ns/1ns
module cps_supervisor_checker
	import cps_pkg::*;
#(
	parameter int TICK_CYC = CPS_TICK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [CPS_PW-1:0] cuff_pressure,
	input wire logic host_link_reset_line,
	input wire logic link_bit_tick,
	input wire logic cpu_reset_n,
	input wire logic pump_on,
	input wire logic pneu_power_on,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	// one tick of slack for timer phase plus synchroniser delay
	localparam int TRIP_CYC = 131 * TICK_CYC + 8;
	localparam int OVP_CYC = 3 * TICK_CYC + 8;
	logic [31:0] arm_cnt_reg;
	logic [31:0] ovp_cnt_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_cnt_reg <= '0;
			ovp_cnt_reg <= '0;
		end else begin
			arm_cnt_reg <= (cuff_pressure > CPS_PRESS_ARM) ? arm_cnt_reg + 32'h1 : '0;
			ovp_cnt_reg <= (cuff_pressure > CPS_OVP_ADULT) ? ovp_cnt_reg + 32'h1 : '0;
		end
	end
	a_trip_cuts_supply: assert property (arm_cnt_reg >= TRIP_CYC |-> !pump_on && !pneu_power_on)
		else $error("supply still on after pressurisation limit");
	a_ovp_ends_pump: assert property (ovp_cnt_reg >= OVP_CYC |-> !pump_on)
		else $error("pump running after over-pressure hold");
	a_maxinf_stops_pump: assert property ((cuff_pressure >= CPS_MAXINF_ADULT) [*6] |-> !pump_on)
		else $error("pump running above inflation cap");
	a_host_reset_cpu: assert property ($rose(host_link_reset_line) |-> ##[1:5] !cpu_reset_n)
		else $error("host reset did not reach processor reset");
	a_tick_period: assert property (link_bit_tick |-> ##20 link_bit_tick)
		else $error("bit tick period wrong");
	a_tick_pulse: assert property (link_bit_tick |=> !link_bit_tick [*8])
		else $error("bit tick too wide");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
endmodule

bind cps_supervisor cps_supervisor_checker #(.TICK_CYC(TICK_CYC)) cps_supervisor_checker_inst (
	.clk(clk), .rst_n(rst_n), .cuff_pressure(cuff_pressure), .host_link_reset_line(host_link_reset_line),
	.link_bit_tick(link_bit_tick), .cpu_reset_n(cpu_reset_n), .pump_on(pump_on), .pneu_power_on(pneu_power_on),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// [dv/tb_top.sv]
// testbench: self-checking bench for the cuff pressure supervisor
`timescale 1ns/1ns
module tb_top
	import cps_pkg::*;
;
	localparam int TK = 20;
	logic clk = 0;
	logic rst_n = 0;
	logic hrst = 0;
	logic link_rx = 1;
	logic [9:0] level = 0;
	logic [9:0] press;
	logic link_tx, tick, cpu_rst_n, pump, pwr, irq;
	logic [6:0] leds;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, r;
	logic awvalid = 0, wvalid = 0, arvalid = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	int err_total = 0;
	int n_tests = 0;
	always #50 clk = ~clk;
	cps_pneu_model cps_pneu_model_inst (.clk(clk), .rst_n(rst_n), .level(level), .pump_on(pump),
		.pneu_power_on(pwr), .cuff_pressure(press));
	cps_supervisor #(.TICK_CYC(TK)) cps_supervisor_inst (.clk(clk), .rst_n(rst_n), .cuff_pressure(press),
		.host_link_reset_line(hrst), .link_rx(link_rx), .link_tx(link_tx), .link_bit_tick(tick),
		.cpu_reset_n(cpu_rst_n), .pump_on(pump), .pneu_power_on(pwr), .valve_led_on(leds), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1));
	task automatic fail(input string m);
		err_total++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask
	task automatic stop_test();
		$display("mismatches %0d, comparisons %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic c, input string m);
		n_tests++;
		if (c !== 1'b1) fail(m);
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clk);
	endtask
	// one register access; a read notes its expected word, a write its response
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
		int n;
		n = 0;
		exp_q.push_back({rs, d});
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
		end
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (bvalid !== 1'b1 && rvalid !== 1'b1 && n < 200);
		if (n >= 200) begin
			fail("bus timeout");
			stop_test();
		end
	endtask
	always @(posedge clk) begin
		if (bvalid === 1'b1 || rvalid === 1'b1) begin
			e = exp_q.pop_front();
			n_tests++;
			if (bvalid === 1'b1 && bresp !== e[33:32]) fail("write response");
			if (rvalid === 1'b1 && {rresp, rdata} !== e) fail("read word");
		end
		if (tick === 1'b1) begin
			n_tests++;
			if (link_tx !== link_rx) fail("link pass-through");
			link_rx <= 1'($urandom_range(1));
		end
	end
	initial begin
		void'($urandom(32'h55c1));
		idle(16);
		rst_n <= 1'b1;
		idle(1);
		xfer(0, CPS_A_STATUS, 32'h1, CPS_RESP_OK);
		xfer(0, CPS_A_CTRL, 32'h0, CPS_RESP_OK);
		xfer(0, CPS_A_IRQ_ST, 32'h0, CPS_RESP_OK);
		xfer(1, 8'h40, 32'h1, CPS_RESP_SLVERR);
		xfer(0, 8'h40, 32'h0, CPS_RESP_SLVERR);
		r = 32'($urandom_range(900));
		xfer(1, CPS_A_SYS, r, CPS_RESP_OK);
		xfer(0, CPS_A_TARGET, r + 32'h28, CPS_RESP_OK);
		xfer(1, CPS_A_SYS, 32'h400, CPS_RESP_OK);
		xfer(0, CPS_A_TARGET, r + 32'h5A, CPS_RESP_OK);
		xfer(1, CPS_A_CTRL, 32'h20, CPS_RESP_OK);
		xfer(1, CPS_A_OUTS, 32'hFE, CPS_RESP_OK);
		idle(2);
		chk(pwr && leds === 7'h7F && !pump, "outputs");
		level <= 10'h00F;
		idle(3 * TK);
		xfer(0, CPS_A_STATUS, 32'h1, CPS_RESP_OK);
		level <= 10'h010;
		idle(2 * TK);
		xfer(0, CPS_A_STATUS, 32'h2, CPS_RESP_OK);
		level <= 10'h00F;
		idle(4);
		xfer(0, CPS_A_STATUS, 32'h1, CPS_RESP_OK);
		xfer(0, CPS_A_TIMER, 32'h0, CPS_RESP_OK);
		xfer(1, CPS_A_IRQ_EN, 32'h1, CPS_RESP_OK);
		level <= 10'h010;
		idle(65 * TK + 40);
		chk(pwr, "adult trip too early");
		idle(65 * TK);
		chk(!pwr && !pump && irq, "adult trip");
		xfer(0, CPS_A_STATUS, 32'h4, CPS_RESP_OK);
		level <= 10'h000;
		xfer(1, CPS_A_IRQ_CLR, 32'h1, CPS_RESP_OK);
		idle(4 * TK);
		chk(!pwr && !irq, "trip held");
		xfer(1, CPS_A_CTRL, 32'h2A, CPS_RESP_OK);
		idle(2);
		chk(pwr, "re-enable");
		level <= 10'h010;
		idle(60 * TK);
		chk(pwr, "infant trip too early");
		idle(5 * TK + 40);
		chk(!pwr, "infant trip");
		level <= 10'h000;
		xfer(1, CPS_A_CTRL, 32'h29, CPS_RESP_OK);
		xfer(1, CPS_A_CTRL, 32'h25, CPS_RESP_OK);
		xfer(1, CPS_A_OUTS, 32'h1, CPS_RESP_OK);
		xfer(1, CPS_A_IRQ_CLR, 32'hF, CPS_RESP_OK);
		idle(2);
		chk(pump, "pump on");
		level <= 10'h0DD;
		idle(3 * TK + 40);
		xfer(0, CPS_A_STATUS, 32'h2, CPS_RESP_OK);
		xfer(0, CPS_A_IRQ_ST, 32'hA, CPS_RESP_OK);
		xfer(0, CPS_A_OUTS, 32'h0, CPS_RESP_OK);
		level <= 10'h000;
		xfer(1, CPS_A_IRQ_CLR, 32'hF, CPS_RESP_OK);
		xfer(1, CPS_A_CTRL, 32'h26, CPS_RESP_OK);
		idle(60 * TK + 40);
		xfer(0, CPS_A_STATUS, 32'h1, CPS_RESP_OK);
		xfer(0, CPS_A_IRQ_ST, 32'h4, CPS_RESP_OK);
		// adult measurement driven above both the inflation cap and the over-pressure limit
		xfer(1, CPS_A_IRQ_CLR, 32'hF, CPS_RESP_OK);
		xfer(1, CPS_A_CTRL, 32'h24, CPS_RESP_OK);
		xfer(1, CPS_A_OUTS, 32'h1, CPS_RESP_OK);
		level <= 10'h141;
		idle(3 * TK + 40);
		chk(!pump, "adult over-pressure pump");
		xfer(0, CPS_A_IRQ_ST, 32'hA, CPS_RESP_OK);
		level <= 10'h000;
		idle(4);
		hrst <= 1'b1;
		idle(6);
		chk(!cpu_rst_n, "host reset");
		hrst <= 1'b0;
		idle(10);
		chk(cpu_rst_n && link_tx !== 1'bx, "host reset release");
		stop_test();
	end
endmodule

// [hdl/cps_lim_if.sv]
// interface: mode limits carried from the limit checker
`timescale 1ns/1ns
interface cps_lim_if;
	logic [1:0] mode;
	logic [9:0] pressure;
	logic [31:0] tmo_cyc;
	logic [31:0] meas_cyc;
	logic [9:0] ovp_lim;
	logic over_ovp;
	logic over_maxinf;
	logic above_arm;
	modport top (output mode, output pressure, input tmo_cyc, input meas_cyc, input ovp_lim,
		input over_ovp, input over_maxinf, input above_arm);
	modport lim (input mode, input pressure, output tmo_cyc, output meas_cyc, output ovp_lim,
		output over_ovp, output over_maxinf, output above_arm);
endinterface

// [hdl/cps_limits.sv]
// module: per-mode limit selection and pressure comparisons
`timescale 1ns/1ns
module cps_limits
	import cps_pkg::*;
#(
	parameter int TICK_CYC = CPS_TICK_CYC
) (
	cps_lim_if.lim lim
);
	wire infant = (lim.mode == CPS_MODE_INFANT);
	wire child = (lim.mode == CPS_MODE_CHILD);
	wire [9:0] maxinf = infant ? CPS_MAXINF_INFANT : (child ? CPS_MAXINF_CHILD : CPS_MAXINF_ADULT);
	assign lim.ovp_lim = infant ? CPS_OVP_INFANT : (child ? CPS_OVP_CHILD : CPS_OVP_ADULT);
	assign lim.tmo_cyc = infant ? 32'(CPS_TMO_SHORT_S * TICK_CYC) : 32'(CPS_TMO_LONG_S * TICK_CYC);
	assign lim.meas_cyc = infant ? 32'(CPS_MEAS_SHORT_S * TICK_CYC) : 32'(CPS_MEAS_LONG_S * TICK_CYC);
	assign lim.over_ovp = (lim.pressure > lim.ovp_lim);
	assign lim.over_maxinf = (lim.pressure >= maxinf);
	assign lim.above_arm = (lim.pressure > CPS_PRESS_ARM);
endmodule

// [hdl/cps_pkg.sv]
// package: constants for the cuff pressure safety supervisor
package cps_pkg;
	localparam int CPS_CLK_HZ = 10_000_000;
	localparam int CPS_PW = 10;
	// pressures in mmHg
	localparam logic [9:0] CPS_PRESS_ARM = 10'h00F;
	localparam logic [9:0] CPS_OVP_ADULT = 10'h140;
	localparam logic [9:0] CPS_OVP_CHILD = 10'h0DC;
	localparam logic [9:0] CPS_OVP_INFANT = 10'h0A5;
	localparam logic [9:0] CPS_MAXINF_ADULT = 10'h118;
	localparam logic [9:0] CPS_MAXINF_CHILD = 10'h0C8;
	localparam logic [9:0] CPS_MAXINF_INFANT = 10'h096;
	localparam logic [9:0] CPS_TGT_ABOVE_SYS = 10'h028;
	localparam logic [9:0] CPS_TGT_STEP_UP = 10'h032;
	// times in seconds; link rate in bit/s, tick and bit periods in clock cycles
	localparam int CPS_TMO_LONG_S = 130;
	localparam int CPS_TMO_SHORT_S = 65;
	localparam int CPS_OVP_HOLD_S = 2;
	localparam int CPS_MEAS_LONG_S = 120;
	localparam int CPS_MEAS_SHORT_S = 60;
	localparam int CPS_LINK_BPS = 500_000;
	localparam int CPS_TICK_CYC = CPS_CLK_HZ;
	localparam int CPS_BIT_CYC = CPS_CLK_HZ / CPS_LINK_BPS;
	// modes
	localparam logic [1:0] CPS_MODE_ADULT = 2'h0;
	localparam logic [1:0] CPS_MODE_CHILD = 2'h1;
	localparam logic [1:0] CPS_MODE_INFANT = 2'h2;
	// register byte addresses
	localparam logic [7:0] CPS_A_CTRL = 8'h00;
	localparam logic [7:0] CPS_A_OUTS = 8'h04;
	localparam logic [7:0] CPS_A_SYS = 8'h08;
	localparam logic [7:0] CPS_A_STATUS = 8'h0C;
	localparam logic [7:0] CPS_A_TARGET = 8'h10;
	localparam logic [7:0] CPS_A_IRQ_ST = 8'h14;
	localparam logic [7:0] CPS_A_IRQ_EN = 8'h18;
	localparam logic [7:0] CPS_A_IRQ_CLR = 8'h1C;
	localparam logic [7:0] CPS_A_TIMER = 8'h20;
	// ctrl fields
	localparam int CPS_C_MODE = 0;
	localparam int CPS_C_MEAS = 2;
	localparam int CPS_C_REARM = 3;
	localparam int CPS_C_SYSOK = 4;
	localparam int CPS_C_PWR = 5;
	localparam int CPS_NOUT = 8;
	// event bits
	localparam int CPS_EV_TMO = 0;
	localparam int CPS_EV_OVP = 1;
	localparam int CPS_EV_MEAS = 2;
	localparam int CPS_EV_MAXINF = 3;
	localparam int CPS_NEV = 4;
	localparam logic [1:0] CPS_RESP_OK = 2'h0;
	localparam logic [1:0] CPS_RESP_SLVERR = 2'h2;
endpackage

// [hdl/cps_supervisor.sv]
// module: cuff pressure safety supervisor with axi4-lite registers
`timescale 1ns/1ns
module cps_supervisor
	import cps_pkg::*;
#(
	parameter int TICK_CYC = CPS_TICK_CYC,
	parameter int NOUT = CPS_NOUT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [CPS_PW-1:0] cuff_pressure,
	input wire logic host_link_reset_line,
	input wire logic link_rx,
	output logic link_tx,
	output logic link_bit_tick,
	output logic cpu_reset_n,
	output logic pump_on,
	output logic pneu_power_on,
	output logic [NOUT-2:0] valve_led_on,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [2:0] {
		CPS_ST_IDLE = 3'b001,
		CPS_ST_ARMED = 3'b010,
		CPS_ST_TRIPPED = 3'b100
	} cps_state_t;

	cps_state_t state_reg;
	cps_state_t state_next;
	cps_lim_if lim_bus();
	logic [7:0] ctrl_reg;
	logic [NOUT-1:0] outs_reg;
	logic [CPS_PW-1:0] sys_reg;
	logic [CPS_PW-1:0] target_reg;
	logic [CPS_NEV-1:0] irq_st_reg;
	logic [CPS_NEV-1:0] irq_en_reg;
	logic [31:0] tmo_cnt_reg;
	logic [31:0] meas_cnt_reg;
	logic [31:0] ovp_cnt_reg;
	logic meas_active_reg;
	logic [1:0] hrst_reg;
	logic [7:0] baud_cnt_reg;
	logic [7:0] aw_addr_reg;
	logic aw_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_have_reg;

	assign lim_bus.mode = ctrl_reg[CPS_C_MODE +: 2];
	assign lim_bus.pressure = cuff_pressure;
	cps_limits #(.TICK_CYC(TICK_CYC)) u_limits (.lim(lim_bus));

	// a write applies once both address and data are held and no response is pending
	wire w_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

	// safety timer state machine, no software in the path
	wire rearm_req = w_fire && (aw_addr_reg == CPS_A_CTRL) && w_strb_reg[0] && w_data_reg[CPS_C_REARM];
	wire tmo_hit = (tmo_cnt_reg >= lim_bus.tmo_cyc - 32'h1);
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CPS_ST_IDLE: begin
				if (lim_bus.above_arm) begin
					state_next = CPS_ST_ARMED;
				end
			end
			CPS_ST_ARMED: begin
				if (tmo_hit) begin
					state_next = CPS_ST_TRIPPED;
				end else if (!lim_bus.above_arm) begin
					state_next = CPS_ST_IDLE;
				end
			end
			CPS_ST_TRIPPED: begin
				if (rearm_req) begin
					state_next = CPS_ST_IDLE;
				end
			end
			default: state_next = CPS_ST_TRIPPED;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= CPS_ST_IDLE;
			tmo_cnt_reg <= 32'h0;
		end else begin
			state_reg <= state_next;
			tmo_cnt_reg <= (state_reg == CPS_ST_ARMED) ? tmo_cnt_reg + 32'h1 : 32'h0;
		end
	end

	// measurement duration and over-pressure persistence
	wire meas_start = w_fire && (aw_addr_reg == CPS_A_CTRL) && w_strb_reg[0] && w_data_reg[CPS_C_MEAS];
	wire meas_tmo = meas_active_reg && (meas_cnt_reg >= lim_bus.meas_cyc - 32'h1);
	wire ovp_end = meas_active_reg && (ovp_cnt_reg >= 32'(CPS_OVP_HOLD_S * TICK_CYC) - 32'h1);
	wire maxinf_hit = meas_active_reg && lim_bus.over_maxinf && outs_reg[0];
	wire tripped = (state_reg == CPS_ST_TRIPPED);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meas_active_reg <= 1'b0;
			meas_cnt_reg <= 32'h0;
			ovp_cnt_reg <= 32'h0;
		end else begin
			if (meas_tmo || ovp_end || tripped) begin
				meas_active_reg <= 1'b0;
			end else if (meas_start) begin
				meas_active_reg <= 1'b1;
			end
			meas_cnt_reg <= meas_active_reg ? meas_cnt_reg + 32'h1 : 32'h0;
			ovp_cnt_reg <= (meas_active_reg && lim_bus.over_ovp) ? ovp_cnt_reg + 32'h1 : 32'h0;
		end
	end

	// inflation target from previous systolic value
	wire sys_write = w_fire && (aw_addr_reg == CPS_A_SYS) && w_strb_reg[0];
	wire [CPS_PW:0] tgt_sum = w_data_reg[CPS_PW] ? {1'b0, target_reg} + {1'b0, CPS_TGT_STEP_UP}
		: {1'b0, w_data_reg[CPS_PW-1:0]} + {1'b0, CPS_TGT_ABOVE_SYS};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_reg <= '0;
			target_reg <= '0;
		end else if (sys_write) begin
			sys_reg <= w_data_reg[CPS_PW-1:0];
			target_reg <= tgt_sum[CPS_PW] ? '1 : tgt_sum[CPS_PW-1:0];
		end
	end

	// host link reset line, power-up reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrst_reg <= 2'h0;
			cpu_reset_n <= 1'b0;
		end else begin
			hrst_reg <= {hrst_reg[0], host_link_reset_line};
			cpu_reset_n <= !hrst_reg[1];
		end
	end

	// bit-rate enable and pass-through of the serial line
	wire baud_wrap = (baud_cnt_reg == 8'(CPS_BIT_CYC - 1));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_cnt_reg <= 8'h0;
			link_bit_tick <= 1'b0;
			link_tx <= 1'b1;
		end else begin
			baud_cnt_reg <= baud_wrap ? 8'h0 : baud_cnt_reg + 8'h1;
			link_bit_tick <= baud_wrap;
			if (baud_wrap) begin
				link_tx <= link_rx;
			end
		end
	end

	// axi4-lite write path
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire w_known = (aw_addr_reg == CPS_A_CTRL) || (aw_addr_reg == CPS_A_OUTS) || (aw_addr_reg == CPS_A_SYS)
		|| (aw_addr_reg == CPS_A_IRQ_EN) || (aw_addr_reg == CPS_A_IRQ_CLR);
	wire [CPS_NEV-1:0] events;
	assign events[CPS_EV_TMO] = (state_reg == CPS_ST_ARMED) && tmo_hit;
	assign events[CPS_EV_OVP] = ovp_end;
	assign events[CPS_EV_MEAS] = meas_tmo;
	assign events[CPS_EV_MAXINF] = maxinf_hit;
	wire [CPS_NEV-1:0] irq_clr = (w_fire && aw_addr_reg == CPS_A_IRQ_CLR && w_strb_reg[0])
		? w_data_reg[CPS_NEV-1:0] : '0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CPS_RESP_OK;
		end else begin
			if (aw_take) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_have_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (w_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_known ? CPS_RESP_OK : CPS_RESP_SLVERR;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// software registers; command bits of ctrl are self-clearing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= 8'h0;
			outs_reg <= '0;
			irq_en_reg <= '0;
			irq_st_reg <= '0;
		end else begin
			if (w_fire && aw_addr_reg == CPS_A_CTRL && w_strb_reg[0]) begin
				ctrl_reg <= w_data_reg[7:0] & ~(8'h1 << CPS_C_MEAS) & ~(8'h1 << CPS_C_REARM);
			end
			if (w_fire && aw_addr_reg == CPS_A_OUTS && w_strb_reg[0]) begin
				outs_reg <= w_data_reg[NOUT-1:0];
			end else if (maxinf_hit) begin
				outs_reg[0] <= 1'b0;
			end
			if (w_fire && aw_addr_reg == CPS_A_IRQ_EN && w_strb_reg[0]) begin
				irq_en_reg <= w_data_reg[CPS_NEV-1:0];
			end
			irq_st_reg <= (irq_st_reg & ~irq_clr) | events;
		end
	end

	// drive pins; a trip removes common supply regardless of software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pump_on <= 1'b0;
			pneu_power_on <= 1'b0;
			valve_led_on <= '0;
			irq <= 1'b0;
		end else begin
			pneu_power_on <= ctrl_reg[CPS_C_PWR] && !tripped && state_next != CPS_ST_TRIPPED;
			pump_on <= outs_reg[0] && meas_active_reg && !tripped;
			valve_led_on <= outs_reg[NOUT-1:1];
			irq <= |(irq_st_reg & irq_en_reg);
		end
	end

	// axi4-lite read path
	wire [31:0] status_word = {24'h0, 2'h0, 1'b0, meas_active_reg, 1'b0, state_reg};
	wire [31:0] rd_word =
		(s_axi_araddr == CPS_A_CTRL) ? {24'h0, ctrl_reg} :
		(s_axi_araddr == CPS_A_OUTS) ? 32'(outs_reg) :
		(s_axi_araddr == CPS_A_SYS) ? 32'(sys_reg) :
		(s_axi_araddr == CPS_A_STATUS) ? status_word :
		(s_axi_araddr == CPS_A_TARGET) ? 32'(target_reg) :
		(s_axi_araddr == CPS_A_IRQ_ST) ? 32'(irq_st_reg) :
		(s_axi_araddr == CPS_A_IRQ_EN) ? 32'(irq_en_reg) :
		(s_axi_araddr == CPS_A_TIMER) ? tmo_cnt_reg : 32'h0;
	wire r_known = (s_axi_araddr == CPS_A_CTRL) || (s_axi_araddr == CPS_A_OUTS) || (s_axi_araddr == CPS_A_SYS)
		|| (s_axi_araddr == CPS_A_STATUS) || (s_axi_araddr == CPS_A_TARGET) || (s_axi_araddr == CPS_A_IRQ_ST)
		|| (s_axi_araddr == CPS_A_IRQ_EN) || (s_axi_araddr == CPS_A_TIMER);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= CPS_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= r_known ? CPS_RESP_OK : CPS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
